// ### core/frtc_consts.svh
// Purpose: offsets, field positions, reset values and step sizes of the
//          free-running timer counter.
// Assumes: byte-wide register port with a 4-bit address.
// Notes:   definitions only.
`ifndef FRTC_CONSTS_SVH
`define FRTC_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define FRTC_OFS_CNT_HI   4'h0
`define FRTC_OFS_CNT_LO   4'h1
`define FRTC_OFS_ALT_HI   4'h2
`define FRTC_OFS_ALT_LO   4'h3
`define FRTC_OFS_STATUS   4'h4
`define FRTC_OFS_CTRL_ONE 4'h5
`define FRTC_OFS_CTRL_TWO 4'h6
`define FRTC_OFS_IRQ_STAT 4'h7
`define FRTC_OFS_IRQ_MASK 4'h8

// ****************************************
// field positions
// ****************************************
`define FRTC_BIT_OVF      5
`define FRTC_BIT_OVF_IE   5
`define FRTC_BIT_CS_HI    3
`define FRTC_BIT_CS_LO    2
`define FRTC_BIT_EDGE     0
`define FRTC_BIT_IRQ_OVF  0

// ****************************************
// values and counts
// ****************************************
`define FRTC_CNT_RESET    16'hFFFC
`define FRTC_CNT_MAX      16'hFFFF
`define FRTC_PRESC_STEP   3'h1
`define FRTC_CNT_STEP     16'h0001

`endif

// ### core/frtc_pkg.sv
// Purpose: types of the free-running timer counter.
// Assumes: nothing.
// Notes:   clock source decoded from the two clock-select bits.
package frtc_pkg;
    // ****************************************
    // timer clock source
    // ****************************************
    typedef enum logic [1:0] {
        src_div4,
        src_div2,
        src_div8,
        src_ext
    } frtc_src_t;
endpackage

// ### core/frtc_core.sv
// Purpose: 16-bit free-running counter with prescaler, external clock,
//          latched two-byte reads and a maskable overflow flag.
// Assumes: the clock edge here stands for the cpu clock falling edge.
// Notes:   one clock domain; the external pin is synchronised.
`timescale 1ns/100ps
`include "frtc_consts.svh"

// Notes on behaviour
// RQ1 - tick is cpu clock over selected factor
// RQ2 - both select bits set: external pin clocks
// RQ3 - edge select bit picks active pin edge
// RQ4 - count changes only on cpu clock edge
// RQ5 - external edges at least four clocks apart
// RQ6 - rollover FFFFh to 0000h sets overflow flag
// RQ7 - irq only when enabled and unmasked
// RQ8 - flag clears: status read, then low access
// RQ9 - alternate low access never clears flag
// RQ10 - two identical read-only counter views
// RQ11 - low byte write reloads FFFCh
// RQ12 - high read first buffers low byte
// RQ13 - buffered low frozen until low read
// RQ14 - lone low read returns live byte
// RQ15 - keeps counting in wait mode
// RQ16 - reset: FFFCh, buffer, flag, prescaler cleared
// RQ17 - codes 00,01,10 divide by 4,2,8
module frtc_core
    import frtc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // cpu state
    input  wire logic        cpu_irq_masked,
    // external clock pin
    input  wire logic        ext_clock_pin,
    // to capture and compare units
    output logic      [15:0] count,
    output logic             timer_tick,
    // interrupts
    output logic             timer_irq,
    output logic             irq
);

    // ****************************************
    // state
    // ****************************************
    logic [2:0]  presc;          // free prescaler
    logic [2:0]  next_presc;
    logic [15:0] next_count;
    logic        ext_s1;         // synchroniser first stage
    logic        ext_s2;         // synchroniser second stage
    logic        ext_s3;         // previous level for edges
    logic        ovf_flag;       // overflow_flag
    logic        next_ovf_flag;
    logic        clr_armed;      // status seen with flag set
    logic        next_clr_armed;
    logic        latched;        // high byte read, low pending
    logic        next_latched;
    logic [7:0]  low_buf;        // frozen low byte
    logic [7:0]  next_low_buf;
    logic [7:0]  next_rdata;
    logic        ovf_irq_en;     // overflow_irq_enable
    logic        next_ovf_irq_en;
    logic [1:0]  clk_sel;        // clock_select_hi, clock_select_lo
    logic [1:0]  next_clk_sel;
    logic        edge_sel;       // ext_edge_select, 1 = rising
    logic        next_edge_sel;
    logic        irq_stat;       // sticky overflow event
    logic        next_irq_stat;
    logic        irq_msk;        // its mask bit
    logic        next_irq_msk;

    // decoded strobes
    frtc_src_t   src;
    logic        ext_edge;
    logic        low_wr;
    logic        rd_hi;
    logic        rd_lo;
    logic        low_access;
    logic        alt_low_access;
    logic        rollover;

    // ****************************************
    // helpers
    // ****************************************
    // map the two select bits to a clock source
    function automatic frtc_src_t decode_src(input logic [1:0] sel);
        case (sel)
            2'b00:   decode_src = src_div4;  // RQ17
            2'b01:   decode_src = src_div2;  // RQ17
            2'b10:   decode_src = src_div8;  // RQ17
            default: decode_src = src_ext;   // RQ2
        endcase
    endfunction

    // true when the address names either low byte
    function automatic logic is_low(input logic [3:0] a);
        is_low = (a == `FRTC_OFS_CNT_LO) || (a == `FRTC_OFS_ALT_LO);
    endfunction

    // ****************************************
    // external pin synchroniser
    // ****************************************
    // only ext_s2 and ext_s3 feed logic; ext_s3 holds the previous level
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= ext_clock_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // ****************************************
    // prescaler and counter
    // ****************************************
    // the prescaler runs freely; a factor change takes effect at
    // once, so the first period after it may be short
    always_comb begin
        src = decode_src(clk_sel);
        // active edge as chosen by software
        ext_edge = edge_sel ? (ext_s2 & ~ext_s3)        // RQ3
                            : (~ext_s2 & ext_s3);       // RQ3
        case (src)
            src_div2: timer_tick = presc[0];            // RQ1
            src_div4: timer_tick = &presc[1:0];         // RQ1
            src_div8: timer_tick = &presc;              // RQ1
            src_ext:  timer_tick = ext_edge;            // RQ2
            default:  timer_tick = 1'b0;
        endcase
        low_wr     = wr && is_low(addr);
        rollover   = timer_tick && !low_wr && (count == `FRTC_CNT_MAX);
        next_presc = presc + `FRTC_PRESC_STEP;
        // a low byte write beats a tick in the same cycle
        if (low_wr) begin
            next_count = `FRTC_CNT_RESET;               // RQ11
        end else if (timer_tick) begin
            next_count = count + `FRTC_CNT_STEP;        // RQ4
        end else begin
            next_count = count;
        end
    end

    // no wait or stop input gates this process
    always_ff @(posedge clock) begin                    // RQ15
        if (!rstn) begin
            presc <= 3'h0;                              // RQ16
            count <= `FRTC_CNT_RESET;                   // RQ16
        end else begin
            presc <= next_presc;
            count <= next_count;
        end
    end

    // ****************************************
    // read path, flag and registers
    // ****************************************
    always_comb begin
        rd_hi = rd && ((addr == `FRTC_OFS_CNT_HI) || (addr == `FRTC_OFS_ALT_HI));
        rd_lo = rd && is_low(addr);
        low_access     = (rd || wr) && (addr == `FRTC_OFS_CNT_LO);
        alt_low_access = (rd || wr) && (addr == `FRTC_OFS_ALT_LO);  // RQ9

        // both views share one buffer
        next_latched = latched;
        next_low_buf = low_buf;
        if (rd_lo) begin
            next_latched = 1'b0;                        // RQ13
        end else if (rd_hi && !latched) begin
            next_latched = 1'b1;                        // RQ12
            next_low_buf = count[7:0];                  // RQ12
        end

        // arm on status read with flag set, disarm on main low access
        next_clr_armed = clr_armed;
        if (rd && (addr == `FRTC_OFS_STATUS) && ovf_flag) begin
            next_clr_armed = 1'b1;                      // RQ8
        end else if (low_access) begin
            next_clr_armed = 1'b0;
        end
        // rollover wins over a clear in the same cycle
        next_ovf_flag = rollover                        // RQ6
                      | (ovf_flag & ~(low_access & clr_armed));  // RQ8

        // sticky event, cleared by reading it; set wins
        next_irq_stat = rollover
                      | (irq_stat & ~(rd && (addr == `FRTC_OFS_IRQ_STAT)));

        // writable control bits
        next_ovf_irq_en = ovf_irq_en;
        next_clk_sel    = clk_sel;
        next_edge_sel   = edge_sel;
        next_irq_msk    = irq_msk;
        if (wr) begin
            case (addr)
                `FRTC_OFS_CTRL_ONE: begin
                    next_ovf_irq_en = wdata[`FRTC_BIT_OVF_IE];
                end
                `FRTC_OFS_CTRL_TWO: begin
                    next_clk_sel  = {wdata[`FRTC_BIT_CS_HI], wdata[`FRTC_BIT_CS_LO]};
                    next_edge_sel = wdata[`FRTC_BIT_EDGE];
                end
                `FRTC_OFS_IRQ_MASK: begin
                    next_irq_msk = wdata[`FRTC_BIT_IRQ_OVF];
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end

        // read data, valid only in the cycle after the strobe
        next_rdata = 8'h00;
        if (rd) begin
            case (addr)
                `FRTC_OFS_CNT_HI,
                `FRTC_OFS_ALT_HI: begin
                    next_rdata = count[15:8];           // RQ10
                end
                `FRTC_OFS_CNT_LO,
                `FRTC_OFS_ALT_LO: begin
                    // buffered after a high read, live otherwise
                    next_rdata = latched ? low_buf : count[7:0];  // RQ14
                end
                `FRTC_OFS_STATUS: begin
                    next_rdata[`FRTC_BIT_OVF] = ovf_flag;
                end
                `FRTC_OFS_CTRL_ONE: begin
                    next_rdata[`FRTC_BIT_OVF_IE] = ovf_irq_en;
                end
                `FRTC_OFS_CTRL_TWO: begin
                    next_rdata[`FRTC_BIT_CS_HI] = clk_sel[1];
                    next_rdata[`FRTC_BIT_CS_LO] = clk_sel[0];
                    next_rdata[`FRTC_BIT_EDGE]  = edge_sel;
                end
                `FRTC_OFS_IRQ_STAT: begin
                    next_rdata[`FRTC_BIT_IRQ_OVF] = irq_stat;
                end
                `FRTC_OFS_IRQ_MASK: begin
                    next_rdata[`FRTC_BIT_IRQ_OVF] = irq_msk;
                end
                default: begin
                    next_rdata = 8'h00;                 // unmapped reads zero
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            latched    <= 1'b0;                         // RQ16
            low_buf    <= 8'h00;                        // RQ16
            clr_armed  <= 1'b0;
            ovf_flag   <= 1'b0;                         // RQ16
            irq_stat   <= 1'b0;
            ovf_irq_en <= 1'b0;
            clk_sel    <= 2'b00;
            edge_sel   <= 1'b0;
            irq_msk    <= 1'b0;
            rdata      <= 8'h00;
        end else begin
            latched    <= next_latched;
            low_buf    <= next_low_buf;
            clr_armed  <= next_clr_armed;
            ovf_flag   <= next_ovf_flag;
            irq_stat   <= next_irq_stat;
            ovf_irq_en <= next_ovf_irq_en;
            clk_sel    <= next_clk_sel;
            edge_sel   <= next_edge_sel;
            irq_msk    <= next_irq_msk;
            rdata      <= next_rdata;
        end
    end

    // ****************************************
    // interrupt outputs
    // ****************************************
    // the request stays pending in the flag until both gates open
    assign timer_irq = ovf_flag && ovf_irq_en && !cpu_irq_masked;  // RQ7
    assign irq       = irq_stat && irq_msk;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    div8_period_a: assert property (                    // RQ1
        (timer_tick && src == src_div8) |=> (!timer_tick || src != src_div8) [*7])
        else $error("divide by 8 tick came early");

    div2_period_a: assert property (                    // RQ17
        (timer_tick && src == src_div2 && !wr) |=> !timer_tick ##1 (timer_tick || src != src_div2))
        else $error("divide by 2 tick spacing wrong");

    ext_only_a: assert property (                       // RQ2
        (src == src_ext && !ext_edge) |-> !timer_tick)
        else $error("tick without external edge");

    ext_edge_dir_a: assert property (                   // RQ3
        (src == src_ext && $rose(ext_s2) && edge_sel) |-> timer_tick)
        else $error("rising edge missed");

    count_step_a: assert property (                     // RQ4
        $changed(count) |-> $past(timer_tick || low_wr))
        else $error("count moved without cause");

    rollover_a: assert property (                       // RQ6
        (timer_tick && !low_wr && count == 16'hFFFF) |=> (ovf_flag && count == 16'h0000))
        else $error("rollover did not set flag");

    irq_gate_a: assert property (                       // RQ7
        (!ovf_irq_en || cpu_irq_masked) |-> !timer_irq)
        else $error("irq while disabled or masked");

    flag_clear_a: assert property (                     // RQ8
        $fell(ovf_flag) |-> $past(low_access && clr_armed))
        else $error("flag cleared out of sequence");

    alt_keeps_a: assert property (                      // RQ9
        (ovf_flag && alt_low_access && !low_access) |=> ovf_flag)
        else $error("alternate access cleared flag");

    views_equal_a: assert property (                    // RQ10
        (rd && addr == `FRTC_OFS_ALT_HI) |=> rdata == $past(count[15:8]))
        else $error("alternate high view differs");

    reload_a: assert property (                         // RQ11
        low_wr |=> count == 16'hFFFC)
        else $error("low write did not reload");

    latch_low_a: assert property (                      // RQ12
        (rd_hi && !latched) ##1 (!rd_lo) [*2] |-> latched && low_buf == $past(count[7:0], 2))
        else $error("low byte not buffered");

    frozen_low_a: assert property (                     // RQ13
        (latched && !rd_lo) |=> $stable(low_buf) && latched)
        else $error("buffered low byte moved");

    live_low_a: assert property (                       // RQ14
        (rd_lo && !latched) |=> rdata == $past(count[7:0]))
        else $error("lone low read not live");

    reset_state_a: assert property (                    // RQ16
        $rose(rstn) |-> (count == 16'hFFFC && !ovf_flag && !latched && presc == 3'h0))
        else $error("reset state wrong");

    overflow_c: cover property (rollover ##1 timer_irq);
    ext_tick_c: cover property (src == src_ext && timer_tick);
    two_byte_c: cover property (rd_hi ##[1:4] rd_lo);
    flag_clear_c: cover property (clr_armed && low_access ##1 !ovf_flag);

endmodule

// ### testbench/frtc_cpu_model.sv
// Purpose: cpu side of the register port
// Assumes: master drives after a rising edge
// Notes:   released lines show inverted values
`timescale 1ns/100ps
module frtc_cpu_model (
    // clock
    input  wire logic        clock,
    // register port
    output logic      [3:0]  addr,
    output logic      [7:0]  wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [7:0]  rdata,
    // cpu state and count view
    output logic             cpu_irq_masked,
    input  wire logic [15:0] count
);
    // idle bus, interrupts masked at start
    initial begin
        addr           = 4'h0;
        wdata          = 8'h00;
        wr             = 1'b0;
        rd             = 1'b0;
        cpu_irq_masked = 1'b1;
    end

    // one-cycle write, then a gap so strobes never double up
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        @(posedge clock);
    endtask

    // global interrupt mask, changed just after a rising edge
    task automatic set_irq_mask(input logic m);
        cpu_irq_masked <= m;
    endtask

    // read: count seen at the taking edge, data one cycle on
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d, output logic [15:0] c);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        c    = count;
        rd   <= 1'b0;
        addr <= ~a;
        @(posedge clock);
        d    = rdata;
    endtask
endmodule

// ### testbench/frtc_core_bench.sv
// Purpose: self-checking bench of the free-running counter
// Assumes: cpu model owns the register port
// Notes:   external pin edges are at least eight clocks apart
`timescale 1ns/100ps
`include "frtc_consts.svh"
module frtc_core_bench;
    // ****
    // signals
    // ****
    logic        clock;
    logic        rstn;
    logic        ext_clock_pin;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        cpu_irq_masked;
    logic [15:0] count;
    logic        timer_tick;
    logic        timer_irq;
    logic        irq;
    int          checks;
    int          bad_count;

    frtc_core frtc_core_inst (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_masked(cpu_irq_masked),
        .ext_clock_pin(ext_clock_pin), .count(count), .timer_tick(timer_tick),
        .timer_irq(timer_irq), .irq(irq));
    frtc_cpu_model cpu (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cpu_irq_masked(cpu_irq_masked), .count(count));

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ****
    // helpers
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // bounded wait for a tick; n is the edges it took
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (timer_tick !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
            print_verdict();
        end
    endtask

    // ****
    // scenarios
    // ****
    // tick spacing for codes 00, 01, 10
    task automatic prescale_test;
        int          div [3] = '{4, 2, 8};
        int          n;
        logic [15:0] c0;
        for (int k = 0; k < 3; k++) begin
            cpu.wr_reg(`FRTC_OFS_CTRL_TWO, 8'(k << 2));
            wait_tick(n);
            c0 = count;
            wait_tick(n);
            chk(16'(n), 16'(div[k]));
            chk(count, c0 + 16'h0001);
        end
    endtask

    // external pin counts only on the chosen edge
    task automatic ext_test;
        logic [15:0] c0;
        for (int e = 0; e < 2; e++) begin
            ext_clock_pin <= ~e[0];
            repeat (8) @(posedge clock);
            cpu.wr_reg(`FRTC_OFS_CTRL_TWO, 8'h0C | 8'(e));
            repeat (8) @(posedge clock);
            c0 = count;
            ext_clock_pin <= e[0];
            repeat (8) @(posedge clock);
            chk(count, c0 + 16'h0001);
            ext_clock_pin <= ~e[0];
            repeat (8) @(posedge clock);
            chk(count, c0 + 16'h0001);
        end
    endtask

    // latched two-byte reads across both views
    task automatic read_test;
        logic [7:0]  d;
        logic [15:0] c1;
        logic [15:0] c2;
        cpu.wr_reg(`FRTC_OFS_CTRL_TWO, 8'h04);
        cpu.rd_reg(`FRTC_OFS_CTRL_TWO, d, c2);
        chk(16'(d), 16'h0004);
        cpu.rd_reg(`FRTC_OFS_CNT_HI, d, c1);
        chk(16'(d), 16'(c1[15:8]));
        repeat (6) @(posedge clock);
        cpu.rd_reg(`FRTC_OFS_ALT_HI, d, c2);
        chk(16'(d), 16'(c2[15:8]));
        cpu.rd_reg(`FRTC_OFS_CNT_LO, d, c2);
        chk(16'(d), 16'(c1[7:0]));
        cpu.rd_reg(`FRTC_OFS_ALT_LO, d, c2);
        chk(16'(d), 16'(c2[7:0]));
        cpu.rd_reg(4'hF, d, c2);
        chk(16'(d), 16'h0000);
    endtask

    // reload, rollover, masking and flag clearing
    task automatic overflow_test;
        logic [7:0]  d;
        logic [15:0] c;
        cpu.wr_reg(`FRTC_OFS_CTRL_TWO, 8'h0C);
        cpu.wr_reg(`FRTC_OFS_ALT_LO, 8'hA5);
        chk(count, `FRTC_CNT_RESET);
        cpu.wr_reg(`FRTC_OFS_CTRL_ONE, 8'h20);
        cpu.wr_reg(`FRTC_OFS_IRQ_MASK, 8'h01);
        cpu.rd_reg(`FRTC_OFS_CTRL_ONE, d, c);
        chk(16'(d), 16'h0020);
        cpu.rd_reg(`FRTC_OFS_IRQ_MASK, d, c);
        chk(16'(d), 16'h0001);
        cpu.wr_reg(`FRTC_OFS_CNT_LO, 8'h00);
        cpu.wr_reg(`FRTC_OFS_CTRL_TWO, 8'h04);
        repeat (16) @(posedge clock);
        chk(16'(timer_irq), 16'h0000);
        chk(16'(irq), 16'h0001);
        cpu.set_irq_mask(1'b0);
        repeat (2) @(posedge clock);
        chk(16'(timer_irq), 16'h0001);
        // low access without a status read first must not clear
        cpu.rd_reg(`FRTC_OFS_CNT_LO, d, c);
        cpu.rd_reg(`FRTC_OFS_STATUS, d, c);
        chk(16'(d[5]), 16'h0001);
        cpu.rd_reg(`FRTC_OFS_ALT_LO, d, c);
        cpu.rd_reg(`FRTC_OFS_STATUS, d, c);
        chk(16'(d[5]), 16'h0001);
        cpu.rd_reg(`FRTC_OFS_CNT_LO, d, c);
        chk(16'(timer_irq), 16'h0000);
        cpu.rd_reg(`FRTC_OFS_IRQ_STAT, d, c);
        chk(16'(d[0]), 16'h0001);
        chk(16'(irq), 16'h0000);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        rstn          = 1'b0;
        ext_clock_pin = 1'b0;
        checks        = 0;
        bad_count     = 0;
        repeat (5) @(posedge clock);
        chk(count, `FRTC_CNT_RESET);
        chk(16'({timer_irq, irq, timer_tick}), 16'h0000);
        rstn <= 1'b1;
        @(posedge clock);
        prescale_test();
        ext_test();
        read_test();
        overflow_test();
        print_verdict();
    end
endmodule
